// >>> drl_pkg.sv
// Constants, types and register map of the differential relay link supervisor
// Function
// (R1) Twelve output flags carry the flags received from the remote end.
// (R2) Twelve user input flags are transmitted to the remote end.
// (R3) One isolated bad frame neither disables protection nor flags link failure.
// (R4) Recurring errors are detected and disable protection while they persist.
// (R5) While disabled by link errors, a link failure flag is asserted.
// (R6) Healthy data again restores protection and clears the failure flag automatically.
// (R7) Phase differential and restraint currents are reported per unit of rated current.
// (R8) Plain two-end mode behaves as the single-channel two-end version.
// (R9) Redundant mode sends and receives all signals on both channels at once.
// (R10) Redundant mode stays ready while only one channel has failed.
// (R11) Three-end mode blocks protection if either channel has failed.
// (R12) Two-channel variant gives twelve received flags per channel.
// (R13) One transmit flag set: channel one only in plain mode, both otherwise; off mode enables neither channel.
// (R14) Second-remote scale ranges 0.10 to 2.00 in 0.01 steps, default 1.00.
// (R15) Operation setting offers off (default), plain, redundant and three-end modes.
// (R16) Consecutive bad frames per channel are counted; threshold declares failure.
package drl_pkg;
  localparam int NFLAG = 12;
  localparam int AW    = 6;
  localparam logic [AW-1:0] OFS_MODE    = 6'h00;
  localparam logic [AW-1:0] OFS_THR     = 6'h04;
  localparam logic [AW-1:0] OFS_SCALE   = 6'h08;
  localparam logic [AW-1:0] OFS_RECIP   = 6'h0c;
  localparam logic [AW-1:0] OFS_STAT    = 6'h10;
  localparam logic [AW-1:0] OFS_IRQ_ST  = 6'h14;
  localparam logic [AW-1:0] OFS_IRQ_CLR = 6'h18;
  localparam logic [AW-1:0] OFS_IRQ_EN  = 6'h1c;
  localparam logic [AW-1:0] OFS_PU_BASE = 6'h20;
  localparam logic [7:0]  THR_MIN   = 8'h02;
  localparam logic [7:0]  THR_MAX   = 8'hff;
  localparam logic [7:0]  THR_RST   = 8'h03;
  localparam logic [7:0]  CNT_MAX   = 8'hff;
  localparam logic [7:0]  SCALE_MIN = 8'h0a;
  localparam logic [7:0]  SCALE_MAX = 8'hc8;
  localparam logic [7:0]  SCALE_RST = 8'h64;
  localparam logic [15:0] RECIP_RST = 16'h0100;
  localparam int PU_SHIFT = 8;
  localparam int EV_FAIL1 = 0;
  localparam int EV_FAIL2 = 1;
  localparam int EV_DOWN  = 2;
  localparam int EV_UP    = 3;
  localparam int NEV      = 4;

  typedef enum logic [1:0] {MODE_OFF, MODE_PLAIN, MODE_REDU, MODE_THREE} drl_mode_t;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [31:0]   wdata;
    logic          we;
    logic          re;
  } drl_bus_req_t;

  typedef struct packed {
    logic             frame_stb;
    logic             frame_ok;
    logic [NFLAG-1:0] flags;
  } drl_rx_t;

  typedef struct packed {
    logic             en;
    logic [NFLAG-1:0] flags;
  } drl_tx_t;

  typedef struct packed {
    logic [2:0][15:0] diff;
    logic [15:0]      bias;
    logic [15:0]      remote2;
  } drl_cur_t;

  typedef logic [3:0][15:0] drl_pu_t;

  typedef struct packed {
    drl_mode_t             mode;
    logic [7:0]            thr;
    logic [7:0]            scale;
    logic [15:0]           recip;
    logic [1:0][7:0]       cnt;
    logic [1:0]            fail;
    logic                  link_fail;
    logic                  prot_en;
    logic [NFLAG-1:0]      rx_flag;
    logic [1:0][NFLAG-1:0] ch_flag;
    drl_tx_t [1:0]         tx;
    logic [NEV-1:0]        irq_st;
    logic [NEV-1:0]        irq_en;
    logic [31:0]           rdata;
    drl_pu_t               pu;
    logic [23:0]           scaled2;
  } drl_state_t;

  localparam drl_state_t ST_RST = '{mode: MODE_OFF, thr: THR_RST, scale: SCALE_RST,
                                    recip: RECIP_RST, default: '0};
endpackage

// >>> drl_link_sup.sv
// Link supervision, flag exchange and per-unit reporting of the line differential relay
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module drl_link_sup (
  input  wire logic                ref_clk_i,
  input  wire logic                sys_rst_i,
  input  wire drl_pkg::drl_bus_req_t bus_i,
  output logic [31:0]              rdata_o,
  input  wire drl_pkg::drl_rx_t    chan1_rx_i,
  input  wire drl_pkg::drl_rx_t    chan2_rx_i,
  input  wire logic [11:0]         transmit_flag_i,
  output drl_pkg::drl_tx_t         chan1_tx_o,
  output drl_pkg::drl_tx_t         chan2_tx_o,
  output logic [11:0]              received_flag_o,
  output logic [11:0]              chan1_received_flag_o,
  output logic [11:0]              chan2_received_flag_o,
  output logic                     link_failure_flag_o,
  output logic                     protection_enable_o,
  input  wire drl_pkg::drl_cur_t   cur_i,
  output drl_pkg::drl_pu_t         pu_o,
  output logic [23:0]              second_remote_scaled_o,
  output logic                     irq_o
);
  import drl_pkg::*;

  drl_state_t     st_ff;
  drl_state_t     nxt_st;
  drl_rx_t [1:0]  rx;
  logic [NEV-1:0] ev;
  logic [NEV-1:0] clr;
  logic [31:0]    rd_val;

  assign rx = {chan2_rx_i, chan1_rx_i};

  function automatic logic [7:0] cnt_upd(input logic [7:0] c, input drl_rx_t r);
    if (r.frame_stb && r.frame_ok) begin
      cnt_upd = 8'h00;
    end else if (r.frame_stb && c != CNT_MAX) begin
      cnt_upd = c + 8'h01;
    end else begin
      cnt_upd = c;
    end
  endfunction

  function automatic logic [7:0] clamp(input logic [7:0] v, input logic [7:0] lo,
                                       input logic [7:0] hi);
    if (v < lo) begin
      clamp = lo;
    end else if (v > hi) begin
      clamp = hi;
    end else begin
      clamp = v;
    end
  endfunction

  function automatic logic link_down(input drl_mode_t m, input logic [1:0] f);
    unique case (m)
      MODE_OFF:   link_down = 1'b0;
      MODE_PLAIN: link_down = f[0];
      MODE_REDU:  link_down = &f; // R10
      MODE_THREE: link_down = |f; // R11
    endcase
  endfunction

  function automatic logic [15:0] to_pu(input logic [15:0] raw, input logic [15:0] rc);
    logic [31:0] p;
    p = 32'(raw) * 32'(rc);
    to_pu = p[PU_SHIFT+15:PU_SHIFT];
  endfunction

  always_comb begin
    clr = '0;
    if (bus_i.we && bus_i.addr == OFS_IRQ_CLR) begin
      clr = bus_i.wdata[NEV-1:0];
    end
    unique case (bus_i.addr)
      OFS_MODE:    rd_val = {30'h0, st_ff.mode};
      OFS_THR:     rd_val = {24'h0, st_ff.thr};
      OFS_SCALE:   rd_val = {24'h0, st_ff.scale};
      OFS_RECIP:   rd_val = {16'h0, st_ff.recip};
      OFS_STAT:    rd_val = {8'h0, st_ff.cnt[1], st_ff.cnt[0], 2'h0, st_ff.fail,
                             st_ff.link_fail, st_ff.prot_en, st_ff.mode};
      OFS_IRQ_ST:  rd_val = {28'h0, st_ff.irq_st};
      OFS_IRQ_EN:  rd_val = {28'h0, st_ff.irq_en};
      6'h20:       rd_val = {16'h0, st_ff.pu[0]};
      6'h24:       rd_val = {16'h0, st_ff.pu[1]};
      6'h28:       rd_val = {16'h0, st_ff.pu[2]};
      6'h2c:       rd_val = {16'h0, st_ff.pu[3]};
      default:     rd_val = 32'h0;
    endcase
  end

  always_comb begin
    nxt_st = st_ff;
    if (bus_i.we) begin
      unique case (bus_i.addr)
        OFS_MODE:   nxt_st.mode = drl_mode_t'(bus_i.wdata[1:0]); // R15
        OFS_THR:    nxt_st.thr = clamp(bus_i.wdata[7:0], THR_MIN, THR_MAX); // R3
        OFS_SCALE:  nxt_st.scale = clamp(bus_i.wdata[7:0], SCALE_MIN, SCALE_MAX); // R14
        OFS_RECIP:  nxt_st.recip = bus_i.wdata[15:0];
        OFS_IRQ_EN: nxt_st.irq_en = bus_i.wdata[NEV-1:0];
        default:    nxt_st.mode = st_ff.mode;
      endcase
    end
    // Both channels are always supervised so a mode change sees current health
    for (int i = 0; i < 2; i++) begin
      nxt_st.cnt[i] = cnt_upd(st_ff.cnt[i], rx[i]); // R16
      nxt_st.fail[i] = nxt_st.cnt[i] >= st_ff.thr; // R4
      if (rx[i].frame_stb && rx[i].frame_ok) begin
        nxt_st.ch_flag[i] = rx[i].flags; // R12
      end
    end
    nxt_st.link_fail = link_down(st_ff.mode, nxt_st.fail); // R8
    nxt_st.prot_en = st_ff.mode != MODE_OFF && !nxt_st.link_fail; // R6
    // Redundant link falls back to the second copy while the first is down
    nxt_st.rx_flag = (st_ff.mode == MODE_REDU && nxt_st.fail[0]) ?
                     nxt_st.ch_flag[1] : nxt_st.ch_flag[0]; // R1
    nxt_st.tx[0].en = st_ff.mode != MODE_OFF; // R2
    nxt_st.tx[0].flags = nxt_st.tx[0].en ? transmit_flag_i : '0;
    nxt_st.tx[1].en = st_ff.mode == MODE_REDU || st_ff.mode == MODE_THREE; // R13
    nxt_st.tx[1].flags = nxt_st.tx[1].en ? transmit_flag_i : '0; // R9
    ev[EV_FAIL1] = nxt_st.fail[0] && !st_ff.fail[0];
    ev[EV_FAIL2] = nxt_st.fail[1] && !st_ff.fail[1];
    ev[EV_DOWN] = nxt_st.link_fail && !st_ff.link_fail;
    ev[EV_UP] = !nxt_st.link_fail && st_ff.link_fail;
    // An event in the clearing cycle survives the clear
    nxt_st.irq_st = (st_ff.irq_st & ~clr) | ev;
    for (int p = 0; p < 3; p++) begin
      nxt_st.pu[p] = to_pu(cur_i.diff[p], st_ff.recip); // R7
    end
    nxt_st.pu[3] = to_pu(cur_i.bias, st_ff.recip);
    nxt_st.scaled2 = 24'(cur_i.remote2) * 24'(st_ff.scale); // R14
    nxt_st.rdata = bus_i.re ? rd_val : 32'h0;
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata_o                = st_ff.rdata;
  assign chan1_tx_o             = st_ff.tx[0];
  assign chan2_tx_o             = st_ff.tx[1];
  assign received_flag_o        = st_ff.rx_flag;
  assign chan1_received_flag_o  = st_ff.ch_flag[0];
  assign chan2_received_flag_o  = st_ff.ch_flag[1];
  assign link_failure_flag_o    = st_ff.link_fail; // R5
  assign protection_enable_o    = st_ff.prot_en;
  assign pu_o                   = st_ff.pu;
  assign second_remote_scaled_o = st_ff.scaled2;
  assign irq_o                  = |(st_ff.irq_st & st_ff.irq_en);

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  property p_r3;
    chan1_rx_i.frame_stb && !chan1_rx_i.frame_ok && st_ff.cnt[0] == 8'h00
      |=> !st_ff.fail[0] && !($past(st_ff.mode) == MODE_PLAIN && link_failure_flag_o);
  endproperty
  a_r3: assert property (p_r3) else $error("single bad frame caused failure"); // R3

  property p_r4;
    chan1_rx_i.frame_stb && !chan1_rx_i.frame_ok && !bus_i.we
      && st_ff.cnt[0] == st_ff.thr - 8'h01 |=> st_ff.fail[0];
  endproperty
  a_r4: assert property (p_r4) else $error("threshold reached without failure"); // R4

  property p_r16;
    chan2_rx_i.frame_stb && chan2_rx_i.frame_ok |=> st_ff.cnt[1] == 8'h00 && !st_ff.fail[1];
  endproperty
  a_r16: assert property (p_r16) else $error("valid frame did not clear count"); // R16

  property p_r5;
    link_failure_flag_o |-> !protection_enable_o && $past(st_ff.mode) != MODE_OFF;
  endproperty
  a_r5: assert property (p_r5) else $error("link failure with protection enabled"); // R5

  property p_r6;
    st_ff.mode == MODE_PLAIN && !bus_i.we && chan1_rx_i.frame_stb && chan1_rx_i.frame_ok
      |=> !link_failure_flag_o && protection_enable_o;
  endproperty
  a_r6: assert property (p_r6) else $error("no recovery after healthy frame"); // R6

  // Link outputs follow a mode write one edge late, so only a settled mode is judged
  property p_r10;
    st_ff.mode == MODE_REDU && $stable(st_ff.mode) && st_ff.fail != 2'b11
      |-> protection_enable_o;
  endproperty
  a_r10: assert property (p_r10) else $error("redundant mode blocked by one channel"); // R10

  property p_r11;
    st_ff.mode == MODE_THREE && $stable(st_ff.mode) && (|st_ff.fail)
      |-> link_failure_flag_o && !protection_enable_o;
  endproperty
  a_r11: assert property (p_r11) else $error("three-end mode not blocked"); // R11

  property p_r13;
    st_ff.mode == MODE_PLAIN && !bus_i.we |=> chan1_tx_o.en && !chan2_tx_o.en;
  endproperty
  a_r13: assert property (p_r13) else $error("plain mode drives second channel"); // R13

  property p_r9;
    st_ff.mode == MODE_REDU && !bus_i.we |=> chan2_tx_o == chan1_tx_o && chan1_tx_o.en;
  endproperty
  a_r9: assert property (p_r9) else $error("redundant channels differ"); // R9

  property p_r2;
    st_ff.mode != MODE_OFF && !bus_i.we |=> chan1_tx_o.flags == $past(transmit_flag_i);
  endproperty
  a_r2: assert property (p_r2) else $error("transmit flags not forwarded"); // R2

  property p_r12;
    chan2_rx_i.frame_stb && chan2_rx_i.frame_ok
      |=> chan2_received_flag_o == $past(chan2_rx_i.flags);
  endproperty
  a_r12: assert property (p_r12) else $error("second channel flags not captured"); // R12

  property p_r14;
    st_ff.scale >= SCALE_MIN && st_ff.scale <= SCALE_MAX;
  endproperty
  a_r14: assert property (p_r14) else $error("scale outside range"); // R14

  property p_r15;
    st_ff.mode == MODE_OFF && $stable(st_ff.mode)
      |-> !protection_enable_o && !link_failure_flag_o && !chan1_tx_o.en;
  endproperty
  a_r15: assert property (p_r15) else $error("off mode still active"); // R15

  property p_r7;
    1'b1 |=> pu_o[3] == 16'((32'($past(cur_i.bias)) * 32'($past(st_ff.recip))) >> PU_SHIFT);
  endproperty
  a_r7: assert property (p_r7) else $error("restraint per-unit value wrong"); // R7

  property p_irq;
    ev[EV_DOWN] |=> st_ff.irq_st[EV_DOWN];
  endproperty
  a_irq: assert property (p_irq) else $error("link down event lost");

  property p_r1;
    st_ff.mode == MODE_PLAIN && chan1_rx_i.frame_stb && chan1_rx_i.frame_ok
      |=> received_flag_o == $past(chan1_rx_i.flags);
  endproperty
  a_r1: assert property (p_r1) else $error("received flags not forwarded"); // R1

  property p_r12_bad;
    chan1_rx_i.frame_stb && !chan1_rx_i.frame_ok |=> $stable(chan1_received_flag_o);
  endproperty
  a_r12_bad: assert property (p_r12_bad) else $error("bad frame flags captured"); // R12

  property p_r8;
    st_ff.mode == MODE_PLAIN |=> link_failure_flag_o == st_ff.fail[0];
  endproperty
  a_r8: assert property (p_r8) else $error("plain mode failure not from channel one"); // R8

  // In redundant mode the second copy stands in only while the first channel is down
  property p_r10_fb;
    st_ff.mode == MODE_REDU
      |=> received_flag_o == (st_ff.fail[0] ? chan2_received_flag_o : chan1_received_flag_o);
  endproperty
  a_r10_fb: assert property (p_r10_fb) else $error("redundant flag source wrong"); // R10

  property p_r16_inc;
    chan1_rx_i.frame_stb && !chan1_rx_i.frame_ok && st_ff.cnt[0] != CNT_MAX
      |=> st_ff.cnt[0] == $past(st_ff.cnt[0]) + 8'h01;
  endproperty
  a_r16_inc: assert property (p_r16_inc) else $error("bad frame not counted"); // R16

  property p_r16_hold;
    !chan1_rx_i.frame_stb |=> $stable(st_ff.cnt[0]);
  endproperty
  a_r16_hold: assert property (p_r16_hold) else $error("count moved without frame"); // R16

  property p_r13_idle;
    !chan2_tx_o.en |-> chan2_tx_o.flags == 12'h000;
  endproperty
  a_r13_idle: assert property (p_r13_idle) else $error("idle channel two sends flags"); // R13

  property p_r2_idle;
    !chan1_tx_o.en |-> chan1_tx_o.flags == 12'h000;
  endproperty
  a_r2_idle: assert property (p_r2_idle) else $error("idle channel one sends flags"); // R2

  property p_rd_idle;
    !bus_i.re |=> rdata_o == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read strobe");

  property p_irq_clr;
    bus_i.we && bus_i.addr == OFS_IRQ_CLR && bus_i.wdata[EV_UP] && !ev[EV_UP]
      |=> !st_ff.irq_st[EV_UP];
  endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("interrupt status not cleared");

  property p_irq_keep;
    st_ff.irq_st[EV_DOWN] && !(bus_i.we && bus_i.addr == OFS_IRQ_CLR)
      |=> st_ff.irq_st[EV_DOWN];
  endproperty
  a_irq_keep: assert property (p_irq_keep) else $error("interrupt status not sticky");

  property p_r6_up;
    $fell(link_failure_flag_o) |-> st_ff.irq_st[EV_UP];
  endproperty
  a_r6_up: assert property (p_r6_up) else $error("recovery event not recorded"); // R6

  property p_r12_ch1;
    chan1_rx_i.frame_stb && chan1_rx_i.frame_ok
      |=> chan1_received_flag_o == $past(chan1_rx_i.flags);
  endproperty
  a_r12_ch1: assert property (p_r12_ch1) else $error("first channel flags not captured"); // R12

  property p_r3_thr;
    st_ff.thr >= THR_MIN;
  endproperty
  a_r3_thr: assert property (p_r3_thr) else $error("threshold below minimum"); // R3

  property p_r7_diff;
    1'b1 |=> pu_o[0] == 16'((32'($past(cur_i.diff[0])) * 32'($past(st_ff.recip))) >> PU_SHIFT);
  endproperty
  a_r7_diff: assert property (p_r7_diff) else $error("phase one per-unit value wrong"); // R7

  property p_r5_src;
    link_failure_flag_o |-> |st_ff.fail;
  endproperty
  a_r5_src: assert property (p_r5_src) else $error("link failure without failed channel"); // R5

  property p_r14_clamp;
    bus_i.we && bus_i.addr == OFS_SCALE && bus_i.wdata[7:0] < SCALE_MIN
      |=> st_ff.scale == SCALE_MIN;
  endproperty
  a_r14_clamp: assert property (p_r14_clamp) else $error("low scale not clamped"); // R14

  property p_r5_stat;
    bus_i.re && bus_i.addr == OFS_STAT
      |=> rdata_o[3] == $past(link_failure_flag_o);
  endproperty
  a_r5_stat: assert property (p_r5_stat) else $error("status misreports link failure"); // R5

  c_fail_recover: cover property (link_failure_flag_o ##[1:50] !link_failure_flag_o);
  c_redu_one: cover property (st_ff.mode == MODE_REDU && st_ff.fail == 2'b01);
  c_three_block: cover property (st_ff.mode == MODE_THREE && st_ff.fail == 2'b10);
  c_irq: cover property (irq_o);
  c_scale_clamp: cover property (bus_i.we && bus_i.addr == OFS_SCALE && bus_i.wdata[7:0] > SCALE_MAX);
endmodule // drl_link_sup

// >>> drl_remote.sv
// Behavioural model of the remote relay feeding one receive channel
`timescale 1ns/1ps
module drl_remote (
  input  wire logic        ref_clk_i,
  output drl_pkg::drl_rx_t rx_o
);
  import drl_pkg::*;
  initial rx_o <= '0;
  // Between frames the flags show the inverse, so stale data never passes for valid
  task automatic send(input logic ok, input logic [NFLAG-1:0] fl);
    @(posedge ref_clk_i);
    rx_o <= '{frame_stb: 1'b1, frame_ok: ok, flags: fl};
    @(posedge ref_clk_i);
    rx_o <= '{frame_stb: 1'b0, frame_ok: 1'b0, flags: ~fl};
  endtask
endmodule // drl_remote

// >>> tb_drl_link_sup.sv
// Self-checking testbench of the link supervisor
`timescale 1ns/1ps
module tb_drl_link_sup;
  import drl_pkg::*;
  logic         ref_clk_i = 1'b0;
  logic         sys_rst_i = 1'b1;
  drl_bus_req_t bus_i     = '0;
  drl_rx_t      c1, c2;
  drl_tx_t      t1, t2;
  drl_cur_t     cur       = '0;
  drl_pu_t      pu;
  logic [11:0]  tx_flag   = '0;
  logic [11:0]  rf, rf1, rf2;
  logic [15:0]  f;
  logic [23:0]  s2;
  logic [31:0]  rdata_o;
  logic [31:0]  seed      = 32'h7b27;
  logic         lf, pe, irq;
  logic         rd_d      = 1'b0;
  logic [31:0]  q[$];
  int           err_count = 0;
  int           checks    = 0;
  int           cyc       = 0;

  drl_link_sup i_drl_link_sup (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .bus_i(bus_i),
    .rdata_o(rdata_o), .chan1_rx_i(c1), .chan2_rx_i(c2), .transmit_flag_i(tx_flag),
    .chan1_tx_o(t1), .chan2_tx_o(t2), .received_flag_o(rf), .chan1_received_flag_o(rf1),
    .chan2_received_flag_o(rf2), .link_failure_flag_o(lf), .protection_enable_o(pe),
    .cur_i(cur), .pu_o(pu), .second_remote_scaled_o(s2), .irq_o(irq));
  drl_remote i_drl_remote_c1 (.ref_clk_i(ref_clk_i), .rx_o(c1));
  drl_remote i_drl_remote_c2 (.ref_clk_i(ref_clk_i), .rx_o(c2));

  always #50 ref_clk_i = ~ref_clk_i;

  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction

  task automatic print_verdict();
    $display("Checks %0d, errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    bus_i <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge ref_clk_i);
    bus_i <= '0;
  endtask

  // Expected read data is queued here and judged by the watcher one cycle later
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    @(posedge ref_clk_i);
    bus_i <= '{addr: a, wdata: '0, we: 1'b0, re: 1'b1};
    q.push_back(e);
    @(posedge ref_clk_i);
    bus_i <= '0;
  endtask

  task automatic w(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask

  task automatic fr(input logic ch2, input logic ok, input int n, input logic [11:0] fl);
    repeat (n) if (ch2) i_drl_remote_c2.send(ok, fl); else i_drl_remote_c1.send(ok, fl);
    w(2);
  endtask

  always @(posedge ref_clk_i) begin
    if (rd_d) chk(rdata_o, q.pop_front());
    rd_d <= bus_i.re;
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      print_verdict();
    end
  end

  initial begin
    repeat (5) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    rd(OFS_MODE, 32'h0);
    rd(OFS_THR, 32'h3);
    rd(OFS_SCALE, 32'h64);
    rd(OFS_RECIP, 32'h100);
    rd(6'h3c, 32'h0);
    chk(pe, 1'b0);
    wr(OFS_SCALE, 32'h5);
    rd(OFS_SCALE, 32'ha);
    wr(OFS_SCALE, 32'hff);
    rd(OFS_SCALE, 32'hc8);
    wr(OFS_MODE, 32'h1);
    f = rnd();
    tx_flag <= f[11:0];
    w(3);
    chk(t1, {1'b1, f[11:0]});
    chk(t2, 13'h0);
    chk(pe, 1'b1);
    f = rnd();
    fr(0, 1, 1, f[11:0]);
    chk(rf, f[11:0]);
    chk(rf1, f[11:0]);
    fr(0, 0, 1, ~f[11:0]);
    chk({lf, pe}, 2'b01);
    chk(rf, f[11:0]);
    wr(OFS_IRQ_EN, 32'h8);
    // Threshold 3: the second error must still leave protection running
    fr(0, 0, 1, f[11:0]);
    chk({lf, pe}, 2'b01);
    fr(0, 0, 1, f[11:0]);
    chk({lf, pe, irq}, 3'b100);
    rd(OFS_STAT, 32'h319);
    fr(0, 1, 1, f[11:0]);
    chk({lf, pe, irq}, 3'b011);
    rd(OFS_IRQ_ST, 32'hd);
    wr(OFS_IRQ_CLR, 32'hf);
    w(1);
    chk(irq, 1'b0);
    rd(OFS_IRQ_ST, 32'h0);
    wr(OFS_MODE, 32'h2);
    w(3);
    chk(t2, {1'b1, tx_flag});
    fr(0, 0, 3, f[11:0]);
    chk({lf, pe}, 2'b01);
    f = rnd();
    fr(1, 1, 1, f[11:0]);
    chk(rf2, f[11:0]);
    chk(rf, f[11:0]);
    wr(OFS_MODE, 32'h3);
    w(3);
    chk({lf, pe}, 2'b10);
    fr(0, 1, 1, f[11:0]);
    chk({lf, pe}, 2'b01);
    fr(1, 0, 3, f[11:0]);
    chk({lf, pe}, 2'b10);
    wr(OFS_RECIP, 32'h200);
    wr(OFS_SCALE, 32'h64);
    cur <= {rnd(), rnd(), rnd(), rnd(), rnd()};
    w(3);
    for (int k = 0; k < 3; k++) chk(pu[k], {cur.diff[k][14:0], 1'b0});
    chk(pu[3], {cur.bias[14:0], 1'b0});
    chk(s2, cur.remote2 * 24'd100);
    rd(OFS_PU_BASE, {16'h0, cur.diff[0][14:0], 1'b0});
    wr(OFS_MODE, 32'h0);
    w(3);
    chk({t1.en, t2.en, pe, lf}, 4'h0);
    print_verdict();
  end
endmodule // tb_drl_link_sup
